// *** src/usb_event_pkg.sv ***
package usb_event_pkg;

    // ==========================================================
    // Register map (index on the plain register port)
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam logic [3:0] OFF_STATUS = 4'h0;
    localparam logic [3:0] OFF_MASK = 4'h1;
    localparam logic [3:0] OFF_VECTOR = 4'h2;

    // ==========================================================
    // Status and mask bit positions
    localparam int BIT_FUNC_RESET = 7;
    localparam int BIT_SUSPEND = 6;
    localparam int BIT_RESUME = 5;
    localparam int BIT_SOF = 4;
    localparam int BIT_PSEUDO_SOF = 3;
    localparam int BIT_SETUP = 2;
    localparam int BIT_RESERVED = 1;
    localparam int BIT_SETUP_OVERWRITE = 0;

    // ==========================================================
    // Reset values and fixed masks
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] WRITABLE_BITS = 8'hFD;
    localparam logic [7:0] VECTOR_NONE = 8'h00;

    // ==========================================================
    // Event bundle from the USB logic, one-cycle pulses except timer_locked
    typedef struct packed {
        logic function_reset;
        logic suspend;
        logic resume;
        logic sof;
        logic pseudo_sof;
        logic timer_locked;
        logic setup_done;
        logic setup_write;
        logic xfer_done;
    } usb_events_s;

    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [3:0] addr;
        logic [7:0] wr_data;
    } reg_req_s;

endpackage

// *** src/usb_event_status_flags.sv ***
// What this block does
// (R1) Resume detection sets status bit 5.
// (R2) Resume flag cannot be set by a write; a vector register write or a status write of one clears it.
// (R3) Start-of-frame packet sets bit 4, even when the frame timer is unlocked.
// (R4) Overwrite of the setup packet buffer sets bit 0.
// (R5) New setup during an open control transfer counts as buffer overwrite.
// (R6) Bit 1 is reserved, never set, reads zero.
// (R7) Artificial frame start from an unlocked timer sets bit 3; vector write clears.
// (R8) Suspend detection sets bit 6; vector write clears it.
// (R9) All flags reset to zero; a mask bit per flag gates the interrupt.
module usb_event_status_flags
    import usb_event_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire usb_events_s ev,
    input wire reg_req_s req,
    output logic [7:0] rd_data,
    output logic irq
);

    // ==========================================================
    // Helpers
    function automatic logic addr_hit(input logic [3:0] a, input logic [3:0] off);
        return a == off;
    endfunction

    // Highest pending unmasked bit as code 1..8, zero when none
    function automatic logic [7:0] vector_code(input logic [7:0] pend);
        logic [7:0] code;
        code = VECTOR_NONE;
        for (int i = 0; i < 8; i++) begin
            if (pend[i]) begin
                code = 8'(i + 1);
            end
        end
        return code;
    endfunction

    // ==========================================================
    // State
    logic [7:0] flags;
    logic [7:0] mask;
    logic in_progress;
    logic [7:0] next_flags;
    logic [7:0] next_mask;
    logic next_in_progress;
    logic [7:0] next_rd_data;

    // ==========================================================
    // Decode
    wire wr_status = req.wr_en && addr_hit(req.addr, OFF_STATUS);
    wire wr_mask = req.wr_en && addr_hit(req.addr, OFF_MASK);
    wire wr_vector = req.wr_en && addr_hit(req.addr, OFF_VECTOR);
    // (R5) Premature setup detect
    wire premature_setup = ev.setup_write && in_progress;
    // (R4) Buffer overwrite detect, also when firmware has not yet seen the last setup
    wire overwrite_hit = premature_setup || (ev.setup_write && flags[BIT_SETUP]);
    // (R7) Only an unlocked timer makes pseudo frames
    wire pseudo_hit = ev.pseudo_sof && !ev.timer_locked;

    logic [7:0] set_bits;
    // (R1) (R3) (R8) Hardware set sources; (R6) bit 1 has none
    assign set_bits[BIT_FUNC_RESET] = ev.function_reset;
    assign set_bits[BIT_SUSPEND] = ev.suspend;
    assign set_bits[BIT_RESUME] = ev.resume;
    assign set_bits[BIT_SOF] = ev.sof;
    assign set_bits[BIT_PSEUDO_SOF] = pseudo_hit;
    assign set_bits[BIT_SETUP] = ev.setup_done;
    assign set_bits[BIT_RESERVED] = 1'b0;
    assign set_bits[BIT_SETUP_OVERWRITE] = overwrite_hit;

    // (R2) Vector write clears all; status write-one also clears; set wins
    wire [7:0] clr_bits = wr_vector ? 8'hFF : (wr_status ? req.wr_data : 8'h00);
    assign next_flags = ((flags & ~clr_bits) | set_bits) & WRITABLE_BITS;
    // (R9) Mask register, reserved bit fixed at zero
    assign next_mask = wr_mask ? (req.wr_data & WRITABLE_BITS) : mask;
    // Transfer stays open from setup completion until its status stage ends
    assign next_in_progress = ev.setup_done ? 1'b1 : (ev.xfer_done ? 1'b0 : in_progress);

    wire [7:0] rd_mux = addr_hit(req.addr, OFF_STATUS) ? flags :
                        addr_hit(req.addr, OFF_MASK) ? mask :
                        addr_hit(req.addr, OFF_VECTOR) ? vector_code(flags & mask) : 8'h00;
    // Read data stand only in the cycle after the strobe
    assign next_rd_data = req.rd_en ? rd_mux : 8'h00;

    // ==========================================================
    // Registers
    // (R9) Interrupt from next values, so it moves on the same edge as the flag
    wire next_irq = |(next_flags & next_mask);

    // (R9) Status flags clear on reset
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            flags <= STATUS_RESET;
        end else begin
            flags <= next_flags;
        end
    end

    // (R9) Mask clears on reset, so nothing interrupts until firmware opts in
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mask <= MASK_RESET;
        end else begin
            mask <= next_mask;
        end
    end

    // (R5) Control transfer tracker
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            in_progress <= 1'b0;
        end else begin
            in_progress <= next_in_progress;
        end
    end

    // Read data register, zero outside the answer cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= next_rd_data;
        end
    end

    // (R9) Interrupt level register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= next_irq;
        end
    end

    // ==========================================================
    // Checks
    sequence s_xfer_open;
        in_progress;
    endsequence
    sequence s_new_setup;
        ev.setup_write;
    endsequence
    sequence s_setup_seen;
        ev.setup_done;
    endsequence
    sequence s_xfer_closed;
        ev.xfer_done && !ev.setup_done;
    endsequence
    sequence s_status_read;
        req.rd_en && addr_hit(req.addr, OFF_STATUS);
    endsequence
    sequence s_idle_bus;
        !req.rd_en;
    endsequence
    sequence s_vector_write;
        wr_vector && !pseudo_hit;
    endsequence

    // (R1) Resume sets
    chk_resume_set: assert property ( // (R1)
        @(posedge clk_sys) disable iff (rst) ev.resume |=> flags[BIT_RESUME])
        else $error("resume flag not set");

    // (R2) Vector write clears all
    chk_vector_clear_all: assert property ( // (R2)
        @(posedge clk_sys) disable iff (rst) (wr_vector && set_bits == 8'h00) |=> flags == 8'h00)
        else $error("vector write did not clear flags");

    // (R2) Resume clears
    chk_resume_clear: assert property ( // (R2)
        @(posedge clk_sys) disable iff (rst) (wr_vector && !ev.resume) |=> !flags[BIT_RESUME])
        else $error("resume flag not cleared");

    // (R3) Frame start sets, locked or not
    chk_sof_set: assert property ( // (R3)
        @(posedge clk_sys) disable iff (rst) ev.sof |=> flags[BIT_SOF])
        else $error("frame start flag not set");

    // (R4) Overwrite of pending setup
    chk_overwrite_set: assert property ( // (R4)
        @(posedge clk_sys) disable iff (rst) (ev.setup_write && flags[BIT_SETUP])
        |=> flags[BIT_SETUP_OVERWRITE])
        else $error("overwrite flag not set");

    // (R5) Setup inside open transfer
    chk_premature_setup: assert property ( // (R5)
        @(posedge clk_sys) disable iff (rst) (s_xfer_open and s_new_setup)
        |=> flags[BIT_SETUP_OVERWRITE])
        else $error("premature setup not flagged");

    // (R5) Setup opens transfer
    chk_xfer_opens: assert property ( // (R5)
        @(posedge clk_sys) disable iff (rst) s_setup_seen |=> in_progress)
        else $error("transfer not opened");

    // (R5) Status stage closes transfer
    chk_xfer_closes: assert property ( // (R5)
        @(posedge clk_sys) disable iff (rst) s_xfer_closed |=> !in_progress)
        else $error("transfer not closed");

    // (R6) Reserved bit stays zero
    chk_reserved_zero: assert property ( // (R6)
        @(posedge clk_sys) disable iff (rst) !flags[BIT_RESERVED] && !mask[BIT_RESERVED])
        else $error("reserved bit set");

    // (R7) Pseudo frame sets
    chk_pseudo_set: assert property ( // (R7)
        @(posedge clk_sys) disable iff (rst) pseudo_hit |=> flags[BIT_PSEUDO_SOF])
        else $error("pseudo frame flag not set");

    // (R7) Pseudo frame clears
    chk_pseudo_clear: assert property ( // (R7)
        @(posedge clk_sys) disable iff (rst) s_vector_write |=> !flags[BIT_PSEUDO_SOF])
        else $error("pseudo frame flag not cleared");

    // (R7) Locked timer makes no pseudo frame
    chk_pseudo_locked: assert property ( // (R7)
        @(posedge clk_sys) disable iff (rst) (ev.timer_locked && !flags[BIT_PSEUDO_SOF])
        |=> !flags[BIT_PSEUDO_SOF])
        else $error("pseudo frame flag set while locked");

    // (R8) Suspend sets
    chk_suspend_set: assert property ( // (R8)
        @(posedge clk_sys) disable iff (rst) ev.suspend |=> flags[BIT_SUSPEND])
        else $error("suspend flag not set");

    // (R8) Suspend clears
    chk_suspend_clear: assert property ( // (R8)
        @(posedge clk_sys) disable iff (rst) (wr_vector && !ev.suspend) |=> !flags[BIT_SUSPEND])
        else $error("suspend flag not cleared");

    // (R9) Reset state
    chk_reset_zero: assert property ( // (R9)
        @(posedge clk_sys) rst |=> (flags == 8'h00 && mask == 8'h00 && !irq))
        else $error("flags not zero after reset");

    // (R9) Interrupt gating
    chk_irq_gate: assert property ( // (R9)
        @(posedge clk_sys) disable iff (rst) irq == |(flags & mask))
        else $error("interrupt not gated by mask");

    // (R9) Mask write lands
    chk_mask_write: assert property ( // (R9)
        @(posedge clk_sys) disable iff (rst) wr_mask
        |=> mask == ($past(req.wr_data) & WRITABLE_BITS))
        else $error("mask write lost");

    // Status read answer
    chk_read_answer: assert property ( // (R9)
        @(posedge clk_sys) disable iff (rst) s_status_read |=> rd_data == $past(flags))
        else $error("status read data wrong");

    // Read data idle level
    chk_read_idle: assert property ( // (R9)
        @(posedge clk_sys) disable iff (rst) s_idle_bus |=> rd_data == 8'h00)
        else $error("read data not zero when idle");

    // Write-one-to-clear on status
    chk_status_w1c: assert property ( // (R2)
        @(posedge clk_sys) disable iff (rst) (wr_status && req.wr_data[BIT_SOF] && !ev.sof)
        |=> !flags[BIT_SOF])
        else $error("status write did not clear");

    // Setup stage complete sets
    chk_setup_set: assert property ( // (R5)
        @(posedge clk_sys) disable iff (rst) ev.setup_done |=> flags[BIT_SETUP])
        else $error("setup flag not set");

    // Function reset sets
    chk_func_reset_set: assert property ( // (R9)
        @(posedge clk_sys) disable iff (rst) ev.function_reset |=> flags[BIT_FUNC_RESET])
        else $error("function reset flag not set");

    // No pending source gives vector code zero
    chk_vector_none: assert property ( // (R9)
        @(posedge clk_sys) disable iff (rst)
        (req.rd_en && addr_hit(req.addr, OFF_VECTOR) && (flags & mask) == 8'h00)
        |=> rd_data == 8'h00)
        else $error("vector code not zero");

endmodule // usb_event_status_flags

// *** tb/testbench.sv ***
module testbench
    import usb_event_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    reg_req_s req = '0;
    logic [8:0] fire = '0;
    usb_events_s ev;
    logic [7:0] rd_data;
    logic irq;
    int error_cnt = 0;
    int check_count = 0;
    int cycles = 0;
    int seed = 32'h292c;
    logic [7:0] mval;
    usb_host_model usb_host_model_inst (.clk_sys(clk_sys), .fire(fire), .ev(ev));
    usb_event_status_flags usb_event_status_flags_inst (.clk_sys(clk_sys), .rst(rst), .ev(ev),
        .req(req), .rd_data(rd_data), .irq(irq));
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    // ==========================================================
    // Shared tasks, each entered just after a rising edge
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        req.wr_en <= 1'b1;
        req.addr <= a;
        req.wr_data <= d;
        @(posedge clk_sys);
        req.wr_en <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe, so sample there
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        req.rd_en <= 1'b1;
        req.addr <= a;
        @(posedge clk_sys);
        req.rd_en <= 1'b0;
        #1;
        check(rd_data, exp);
        @(posedge clk_sys);
    endtask
    task automatic pulse(input logic [8:0] f, input logic lk);
        fire <= f | {5'h00, lk, 3'h0};
        @(posedge clk_sys);
        fire <= {5'h00, lk, 3'h0};
        repeat (2) @(posedge clk_sys);
    endtask
    function automatic logic [7:0] expect_flags(input logic [8:0] f, input logic lk);
        expect_flags = {f[8:5], f[4] & ~lk, f[2], 2'b00};
    endfunction
    task automatic give_verdict();
        $display("checks=%0d errors=%0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ==========================================================
    // Hang guard, far above the under two hundred cycles the run needs
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            give_verdict();
        end
    end
    // ==========================================================
    // Main sequence
    initial begin
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        rd(OFF_STATUS, STATUS_RESET);
        rd(OFF_MASK, MASK_RESET);
        for (int i = 2; i < 9; i++) begin
            for (int lk = 0; lk < 2; lk++) begin
                if (i != 3) begin
                    pulse(9'h001 << i, lk[0]);
                    rd(OFF_STATUS, expect_flags(9'h001 << i, lk[0]));
                    wr(OFF_VECTOR, 8'($random(seed)));
                    rd(OFF_STATUS, 8'h00);
                end
            end
        end
        pulse(9'h004, 1'b0);
        pulse(9'h002, 1'b0);
        rd(OFF_STATUS, 8'h05);
        wr(OFF_VECTOR, 8'h00);
        pulse(9'h002, 1'b0);
        rd(OFF_STATUS, 8'h01);
        pulse(9'h001, 1'b0);
        wr(OFF_VECTOR, 8'h00);
        pulse(9'h002, 1'b0);
        rd(OFF_STATUS, 8'h00);
        for (int k = 0; k < 8; k++) begin
            mval = 8'($random(seed));
            wr(OFF_MASK, mval);
            rd(OFF_MASK, mval & WRITABLE_BITS);
        end
        wr(OFF_MASK, 8'h20);
        pulse(9'h040, 1'b0);
        #1;
        check({7'h00, irq}, 8'h01);
        @(posedge clk_sys);
        wr(OFF_MASK, 8'hDF);
        repeat (2) @(posedge clk_sys);
        check({7'h00, irq}, 8'h00);
        wr(OFF_MASK, 8'h20);
        rd(OFF_VECTOR, 8'h06);
        rd(4'hF, 8'h00);
        wr(OFF_STATUS, 8'h20);
        rd(OFF_STATUS, 8'h00);
        give_verdict();
    end
endmodule // testbench

// *** tb/usb_host_model.sv ***
module usb_host_model
    import usb_event_pkg::*;
(
    input wire logic clk_sys,
    input wire logic [8:0] fire,
    output usb_events_s ev
);
    timeunit 1ns;
    timeprecision 1ps;
    // Bus-side detectors report one clean pulse a cycle, timer lock as a level
    always_ff @(posedge clk_sys) begin
        ev <= usb_events_s'(fire);
    end
endmodule // usb_host_model
